// [motion_cfg_pkg.sv]
// Package: register map, field widths, reset values and enumerations of the block
package motion_cfg_pkg;
  localparam logic [7:0] ENC_MODE_OFFSET = 8'h1E;
  localparam logic [7:0] FAULT_FLAG_OFFSET = 8'h1F;
  localparam logic [7:0] DECEL_SHAPE_OFFSET = 8'h20;
  localparam logic [7:0] FAULT_CODE_OFFSET = 8'h21;
  localparam logic [7:0] ATTN_MASK_OFFSET = 8'h22;
  localparam logic [7:0] LINE_COUNT_OFFSET = 8'h23;
  localparam logic [7:0] STATUS_OFFSET = 8'h24;
  localparam int DATA_WIDTH = 16;
  localparam int QUAD_SHIFT = 2;
  localparam logic [15:0] LINE_COUNT_RESET = 16'h03E8;
  localparam logic [15:0] LINE_COUNT_MIN = 16'h0001;
  localparam logic [15:0] LINE_COUNT_MAX = 16'h07D0;
  localparam logic [0:0] ENC_MODE_RESET = 1'h0;
  localparam logic [0:0] FAULT_FLAG_RESET = 1'h0;
  localparam logic [0:0] ATTN_MASK_RESET = 1'h0;
  localparam logic [7:0] FAULT_CODE_RESET = 8'h00;

  typedef enum logic [1:0] {
    SHAPE_NONE = 2'h0,
    SHAPE_LINEAR = 2'h1,
    SHAPE_TRIANGLE = 2'h2,
    SHAPE_SINE = 2'h3
  } decel_shape_type;

  typedef enum {
    PROG_IDLE,
    PROG_RUN,
    PROG_END_WAIT
  } prog_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic fault;
    logic [7:0] code;
  } fault_event_type;
endpackage

// [sync2.sv]
// Two flip-flop synchroniser for one level
module sync2 (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic stage1;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// [motion_cfg.sv]
// Configuration and status logic of a stepper motion controller
// What this block does
// [RULE1] Shape 1 linear, 2 triangle, 3 sinusoidal
// [RULE2] Shape resets to linear
// [RULE3] Shape 3 gives softer s-curve ends
// [RULE4] Program end instruction stops program execution
// [RULE5] Immediate end waits for active move
// [RULE6] Encoder mode bit selects steps or counts
// [RULE7] Encoder mode loads position from quadrature count
// [RULE8] Stall and position upkeep only in encoder mode
// [RULE9] Read-only fault flag, default zero
// [RULE10] Program start clears fault flag
// [RULE11] Fault code read or zero write clears
// [RULE12] Attention mask drives fault flag out
// [RULE13] Line count scales; four counts per line
// [RULE14] Host picks microstep above lines times eight
// [RULE15] Fault code holds most recent error
// [RULE16] Out-of-range shape writes are ignored
module motion_cfg
  import motion_cfg_pkg::*;
#(
  parameter int POS_WIDTH = 32
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire reg_req_type req,
  output logic [15:0] rdata,
  input wire fault_event_type fault_in,
  input wire logic prog_start,
  input wire logic prog_end_instr,
  input wire logic imm_end_cmd,
  input wire logic move_active,
  input wire logic [POS_WIDTH-1:0] step_count,
  input wire logic enc_a,
  input wire logic enc_b,
  output logic prog_running,
  output logic [POS_WIDTH-1:0] position,
  output logic [POS_WIDTH-1:0] quad_count,
  output decel_shape_type decel_shape_select,
  output logic encoder_mode_on,
  output logic stall_detect_en,
  output logic pos_maint_en,
  output logic [17:0] counts_per_rev,
  output logic attention_out
);
  logic fault_status_flag;
  logic [7:0] fault_code_hold;
  logic attention_mask;
  logic [15:0] encoder_line_count;
  prog_state_type prog_state;
  logic a_sync, b_sync, a_prev, b_prev;
  logic code_rd, code_zero_wr;

  sync2 sync_a (.mclk(mclk), .resetn(resetn), .din(enc_a), .dout(a_sync));
  sync2 sync_b (.mclk(mclk), .resetn(resetn), .din(enc_b), .dout(b_sync));

  assign code_rd = req.rd && (req.addr == FAULT_CODE_OFFSET);
  assign code_zero_wr = req.wr && (req.addr == FAULT_CODE_OFFSET) && (req.wdata == 16'h0000);

  // Shape register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      decel_shape_select <= SHAPE_LINEAR; // [RULE2]
    end else if (req.wr && req.addr == DECEL_SHAPE_OFFSET) begin
      if (req.wdata[15:2] == 14'h0000 && req.wdata[1:0] != 2'h0) begin // [RULE16]
        decel_shape_select <= decel_shape_type'(req.wdata[1:0]); // [RULE1] [RULE3]
      end
    end
  end

  // Configuration bits
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      encoder_mode_on <= ENC_MODE_RESET[0]; // [RULE6]
      attention_mask <= ATTN_MASK_RESET[0];
      encoder_line_count <= LINE_COUNT_RESET;
    end else if (req.wr) begin
      if (req.addr == ENC_MODE_OFFSET) begin
        encoder_mode_on <= req.wdata[0]; // [RULE6]
      end
      if (req.addr == ATTN_MASK_OFFSET) begin
        attention_mask <= req.wdata[0];
      end
      if (req.addr == LINE_COUNT_OFFSET && req.wdata >= LINE_COUNT_MIN &&
          req.wdata <= LINE_COUNT_MAX) begin
        encoder_line_count <= req.wdata;
      end
    end
  end

  // Four counts per line
  assign counts_per_rev = {encoder_line_count, 2'b00}; // [RULE13]

  // Encoder functions gated by mode
  assign stall_detect_en = encoder_mode_on; // [RULE8]
  assign pos_maint_en = encoder_mode_on; // [RULE8]

  // Quadrature decode, one count per edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      a_prev <= 1'b0;
      b_prev <= 1'b0;
      quad_count <= '0;
    end else begin
      a_prev <= a_sync;
      b_prev <= b_sync;
      if ((a_sync ^ a_prev) ^ (b_sync ^ b_prev)) begin // [RULE13]
        if (a_prev ^ b_sync) begin
          quad_count <= quad_count + 1'b1;
        end else begin
          quad_count <= quad_count - 1'b1;
        end
      end
    end
  end

  // Position source
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      position <= '0;
    end else begin
      position <= encoder_mode_on ? quad_count : step_count; // [RULE7]
    end
  end

  // Program sequencing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prog_state <= PROG_IDLE;
    end else begin
      case (prog_state)
        PROG_IDLE: begin
          if (prog_start) begin
            prog_state <= PROG_RUN;
          end
        end
        PROG_RUN: begin
          if (prog_end_instr) begin
            prog_state <= PROG_IDLE; // [RULE4]
          end else if (imm_end_cmd) begin
            prog_state <= move_active ? PROG_END_WAIT : PROG_IDLE; // [RULE5]
          end
        end
        PROG_END_WAIT: begin
          if (!move_active) begin
            prog_state <= PROG_IDLE; // [RULE5]
          end
        end
        default: prog_state <= PROG_IDLE;
      endcase
    end
  end

  assign prog_running = (prog_state != PROG_IDLE);

  // Fault flag and code; a new fault wins over any clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fault_status_flag <= FAULT_FLAG_RESET[0]; // [RULE9]
      fault_code_hold <= FAULT_CODE_RESET;
    end else if (fault_in.fault) begin
      fault_status_flag <= 1'b1; // [RULE9]
      fault_code_hold <= fault_in.code; // [RULE15]
    end else begin
      if (prog_start && prog_state == PROG_IDLE) begin
        fault_status_flag <= 1'b0; // [RULE10]
      end else if (code_rd || code_zero_wr) begin
        fault_status_flag <= 1'b0; // [RULE11]
      end
      if (code_zero_wr) begin
        fault_code_hold <= FAULT_CODE_RESET; // [RULE11]
      end
    end
  end

  // Attention output
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      attention_out <= 1'b0;
    end else begin
      attention_out <= attention_mask & fault_status_flag; // [RULE12]
    end
  end

  // Read data, registered
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        ENC_MODE_OFFSET: rdata <= {15'h0000, encoder_mode_on};
        FAULT_FLAG_OFFSET: rdata <= {15'h0000, fault_status_flag}; // [RULE9]
        DECEL_SHAPE_OFFSET: rdata <= {14'h0000, decel_shape_select};
        FAULT_CODE_OFFSET: rdata <= {8'h00, fault_code_hold};
        ATTN_MASK_OFFSET: rdata <= {15'h0000, attention_mask};
        LINE_COUNT_OFFSET: rdata <= encoder_line_count;
        STATUS_OFFSET: rdata <= {14'h0000, prog_state == PROG_END_WAIT, prog_running};
        default: rdata <= 16'h0000;
      endcase
    end
  end

  // Checks
  property shape_reject_p;
    @(posedge mclk) disable iff (!resetn)
      (req.wr && req.addr == DECEL_SHAPE_OFFSET && req.wdata == 16'h0000)
      |=> $stable(decel_shape_select);
  endproperty
  shape_reject_a: assert property (shape_reject_p) else $error("bad shape accepted"); // [RULE16]

  shape_legal_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE1]
    decel_shape_select != SHAPE_NONE) else $error("shape zero held");

  shape_write_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE1]
    (req.wr && req.addr == DECEL_SHAPE_OFFSET &&
     req.wdata >= 16'h0001 && req.wdata <= 16'h0003)
    |=> decel_shape_select == decel_shape_type'($past(req.wdata[1:0])))
    else $error("shape not taken");

  shape_reset_a: assert property (@(posedge mclk) // [RULE2]
    !resetn |=> decel_shape_select == SHAPE_LINEAR) else $error("shape reset wrong");

  sequence fault_seen_s;
    fault_in.fault;
  endsequence
  sequence flag_up_s;
    fault_status_flag && fault_code_hold == $past(fault_in.code);
  endsequence
  fault_set_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE15]
    fault_seen_s |=> flag_up_s) else $error("fault not latched");

  code_keep_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE15]
    (!fault_in.fault && !code_zero_wr) |=> $stable(fault_code_hold))
    else $error("code changed");

  flag_read_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE9]
    (req.rd && req.addr == FAULT_FLAG_OFFSET)
    |=> rdata == {15'h0000, $past(fault_status_flag)}) else $error("flag read");

  fault_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE11]
    (code_rd && !fault_in.fault) |=> !fault_status_flag) else $error("read no clear");

  code_zero_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE11]
    (code_zero_wr && !fault_in.fault)
    |=> !fault_status_flag && fault_code_hold == FAULT_CODE_RESET)
    else $error("zero no clear");

  fault_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE11]
    (fault_status_flag && !fault_in.fault && !code_rd && !code_zero_wr && !prog_start)
    |=> fault_status_flag) else $error("flag dropped");

  start_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE10]
    (prog_start && prog_state == PROG_IDLE && !fault_in.fault) |=> !fault_status_flag)
    else $error("start no clear");

  attn_follow_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE12]
    attention_out == $past(attention_mask && fault_status_flag)) else $error("attention");

  attn_masked_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE12]
    !attention_mask |=> !attention_out) else $error("attention unmasked");

  sequence imm_end_busy_s;
    prog_state == PROG_RUN && !prog_end_instr && imm_end_cmd && move_active;
  endsequence
  sequence imm_end_free_s;
    prog_state == PROG_RUN && !prog_end_instr && imm_end_cmd && !move_active;
  endsequence
  sequence end_waiting_s;
    prog_running && prog_state == PROG_END_WAIT;
  endsequence
  imm_defer_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE5]
    imm_end_busy_s |=> end_waiting_s) else $error("end not deferred");

  imm_stop_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE5]
    imm_end_free_s |=> !prog_running) else $error("immediate end missed");

  end_wait_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE5]
    (prog_state == PROG_END_WAIT && move_active) |=> prog_running) else $error("early end");

  wait_done_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE5]
    (prog_state == PROG_END_WAIT && !move_active) |=> !prog_running) else $error("late end");

  prog_end_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE4]
    (prog_state == PROG_RUN && prog_end_instr) |=> !prog_running) else $error("no end");

  mode_write_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE6]
    (req.wr && req.addr == ENC_MODE_OFFSET)
    |=> encoder_mode_on == $past(req.wdata[0])) else $error("mode write");

  step_src_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE6]
    !encoder_mode_on |=> position == $past(step_count)) else $error("step source");

  pos_src_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE7]
    encoder_mode_on |=> position == $past(quad_count)) else $error("pos source");

  enc_gate_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE8]
    !encoder_mode_on |-> !stall_detect_en && !pos_maint_en) else $error("gate");

  enc_open_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE8]
    encoder_mode_on |-> stall_detect_en && pos_maint_en) else $error("gate shut");

  quad_step_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE13]
    $changed(quad_count) |-> (quad_count - $past(quad_count) == POS_WIDTH'(1)) ||
    ($past(quad_count) - quad_count == POS_WIDTH'(1))) else $error("quad jump");

  quad_idle_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE13]
    (a_sync == a_prev && b_sync == b_prev) |=> $stable(quad_count)) else $error("quad drift");

  line_range_a: assert property (@(posedge mclk) disable iff (!resetn) // [RULE13]
    encoder_line_count >= LINE_COUNT_MIN && encoder_line_count <= LINE_COUNT_MAX)
    else $error("line count range");
endmodule

// [host_model.sv]
// Host model issuing register reads and writes
module host_model
  import motion_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] rdata,
  output reg_req_type req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  // Microstep floor: line count times eight over full steps per rev
  localparam int FULL_STEPS = 200;
  localparam int MICROSTEP_RES = 256;
  // Line count writes are capped so the chosen microstep stays above the floor
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [15:0] line_max;
    line_max = 16'(MICROSTEP_RES * FULL_STEPS / 8);
    if (a == LINE_COUNT_OFFSET && v > line_max) begin
      v = line_max;
    end
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    req <= '0;
    #1 v = rdata;
  endtask
endmodule

// [test_motion_cfg.sv]
// Self-checking testbench of the motion configuration block
module test_motion_cfg
  import motion_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0;
  logic resetn = 0;
  reg_req_type req;
  logic [15:0] rdata;
  logic [15:0] d;
  fault_event_type fault_in = '0;
  logic prog_start = 0;
  logic prog_end_instr = 0;
  logic imm_end_cmd = 0;
  logic move_active = 0;
  logic enc_a = 0;
  logic enc_b = 0;
  logic [31:0] step_count = '0;
  logic [31:0] position;
  logic [31:0] quad_count;
  decel_shape_type shape;
  logic enc_on, stall_en, maint_en, running, attn;
  logic [17:0] cpr;
  int fail_count = 0;
  int total_checks = 0;
  localparam logic [1:0] GRAY [4] = '{2'b10, 2'b11, 2'b01, 2'b00};

  motion_cfg u_motion_cfg (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata),
    .fault_in(fault_in), .prog_start(prog_start), .prog_end_instr(prog_end_instr),
    .imm_end_cmd(imm_end_cmd), .move_active(move_active), .step_count(step_count),
    .enc_a(enc_a), .enc_b(enc_b), .prog_running(running), .position(position),
    .quad_count(quad_count), .decel_shape_select(shape), .encoder_mode_on(enc_on),
    .stall_detect_en(stall_en), .pos_maint_en(maint_en), .counts_per_rev(cpr),
    .attention_out(attn));
  host_model u_host (.mclk(mclk), .rdata(rdata), .req(req));

  initial forever #5 mclk = ~mclk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic pulse(input int k);
    @(posedge mclk);
    case (k)
      0: prog_start <= 1;
      1: prog_end_instr <= 1;
      default: imm_end_cmd <= 1;
    endcase
    @(posedge mclk);
    prog_start <= 0;
    prog_end_instr <= 0;
    imm_end_cmd <= 0;
    #1;
  endtask

  task automatic raise(input logic [7:0] c);
    @(posedge mclk) fault_in <= '{fault: 1'b1, code: c};
    @(posedge mclk) fault_in <= '0;
  endtask

  task automatic t_reset;
    u_host.rd(DECEL_SHAPE_OFFSET, d);
    chk("shape", 1, d);
    u_host.rd(FAULT_FLAG_OFFSET, d);
    chk("flag", 0, d);
    chk("enc off", 0, enc_on);
    chk("stall", 0, stall_en);
    chk("maint", 0, maint_en);
    $display("reset test done");
  endtask

  task automatic t_shape;
    for (int s = 1; s <= 3; s++) begin
      u_host.wr(DECEL_SHAPE_OFFSET, 16'(s));
      chk("shape out", s, shape);
    end
    u_host.wr(DECEL_SHAPE_OFFSET, 16'h0000);
    u_host.wr(DECEL_SHAPE_OFFSET, 16'h0004);
    u_host.rd(DECEL_SHAPE_OFFSET, d);
    chk("shape kept", 3, d);
    $display("shape test done");
  endtask

  task automatic t_enc;
    @(posedge mclk) step_count <= 32'h00001234;
    repeat (2) @(posedge mclk);
    #1 chk("pos steps", 32'h00001234, position);
    u_host.wr(ENC_MODE_OFFSET, 16'h0001);
    chk("enc on", 1, enc_on);
    chk("stall on", 1, stall_en);
    chk("maint on", 1, maint_en);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) {enc_a, enc_b} <= GRAY[i];
      repeat (5) @(posedge mclk);
    end
    #1 chk("quad", 4, quad_count[31] ? -quad_count : quad_count);
    chk("pos enc", 4, position[31] ? -position : position);
    u_host.wr(LINE_COUNT_OFFSET, 16'h01F4);
    u_host.wr(LINE_COUNT_OFFSET, 16'h0000);
    chk("cpr", 2000, cpr);
    $display("encoder test done");
  endtask

  task automatic t_fault;
    u_host.wr(ATTN_MASK_OFFSET, 16'h0001);
    raise(8'h56);
    raise(8'h57);
    u_host.wr(FAULT_CODE_OFFSET, 16'h0003);
    u_host.rd(FAULT_FLAG_OFFSET, d);
    chk("flag set", 1, d);
    chk("attn set", 1, attn);
    u_host.rd(FAULT_CODE_OFFSET, d);
    chk("code", 16'h0057, d);
    u_host.rd(FAULT_FLAG_OFFSET, d);
    chk("read clr", 0, d);
    chk("attn clr", 0, attn);
    raise(8'h21);
    u_host.wr(FAULT_CODE_OFFSET, 16'h0000);
    u_host.rd(FAULT_FLAG_OFFSET, d);
    chk("zero clr", 0, d);
    u_host.rd(FAULT_CODE_OFFSET, d);
    chk("code clr", 0, d);
    u_host.wr(ATTN_MASK_OFFSET, 16'h0000);
    raise(8'h22);
    u_host.rd(FAULT_FLAG_OFFSET, d);
    chk("flag up", 1, d);
    chk("attn masked", 0, attn);
    pulse(0);
    u_host.rd(FAULT_FLAG_OFFSET, d);
    chk("start clr", 0, d);
    pulse(1);
    $display("fault test done");
  endtask

  task automatic t_prog;
    pulse(0);
    chk("run", 1, running);
    pulse(1);
    chk("end", 0, running);
    pulse(0);
    @(posedge mclk) move_active <= 1;
    pulse(2);
    repeat (3) @(posedge mclk);
    #1 chk("wait", 1, running);
    u_host.rd(STATUS_OFFSET, d);
    chk("status", 16'h0003, d);
    @(posedge mclk) move_active <= 0;
    repeat (2) @(posedge mclk);
    #1 chk("done", 0, running);
    pulse(0);
    pulse(2);
    chk("imm stop", 0, running);
    $display("program test done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1;
    t_reset();
    t_shape();
    t_enc();
    t_fault();
    t_prog();
    close_out();
  end

  initial begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule
